//--- hdl/acs_status_core.sv
// Status word, accumulator saturation and AHB-Lite register access.
`timescale 1ns/10ps
module acs_status_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire acs_pkg::acs_alu_op_t alu_op,
  input wire acs_pkg::acs_acc_op_t acc_op,
  input wire logic repeat_busy,
  output logic [15:0] cpu_status_word,
  output logic [39:0] acc_a,
  output logic [39:0] acc_b,
  output logic [15:0] alu_result,
  output logic [3:0] ipl_effective,
  output logic user_int_disable,
  output logic arith_warning_trap,
  output logic irq
);
  import acs_pkg::*;

  acs_state_t st;
  acs_state_t nx;
  acs_alu_res_t alu_res;
  acs_acc_res_t ares;
  acs_sat_mode_t mode_sel;
  logic rd_req;
  logic wr_req;
  logic clip_new;
  logic [IRQ_W-1:0] events;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding of the saturation mode, shared by both accumulators.
  function automatic acs_sat_mode_t acs_mode(input logic sat_en, input logic sat31);
    acs_sat_mode_t m;
    if (!sat_en) begin
      m = ACS_MODE_WRAP;
    end else if (sat31) begin
      m = ACS_MODE_SAT31;
    end else begin
      m = ACS_MODE_SAT39;
    end
    return m;
  endfunction : acs_mode

  // One pass of an accumulator through the sign-extended 41-bit adder and saturation logic.
  function automatic acs_acc_res_t acc_step(input logic [39:0] acc, input acs_acc_op_t op,
                                            input acs_sat_mode_t mode);
    acs_acc_res_t r;
    logic [40:0] ext;
    logic [40:0] sum;
    logic ovf39;
    logic ovf31;
    ext = {op.operand[39], op.operand};
    sum = op.subtract ? ({acc[39], acc} - ext) : ({acc[39], acc} + ext);
    ovf39 = (sum[40] != sum[39]);
    ovf31 = !((&sum[40:31]) || !(|sum[40:31]));
    r.value = sum[39:0];
    r.clip = ovf39;
    r.guard = 1'b0;
    case (mode)
      ACS_MODE_WRAP: begin
        r.value = sum[39:0];
        r.clip = ovf39;
        r.guard = !((&sum[39:31]) || !(|sum[39:31]));
      end
      ACS_MODE_SAT39: begin
        if (ovf39) begin
          r.value = sum[40] ? SAT39_NEG : SAT39_POS;
        end
        r.clip = ovf39;
        r.guard = !((&r.value[39:31]) || !(|r.value[39:31]));
      end
      ACS_MODE_SAT31: begin
        if (ovf31) begin
          r.value = sum[40] ? SAT31_NEG : SAT31_POS;
        end
        r.clip = ovf31;
        // Guard bits only carry the sign of bit 31 in this mode, so guard excess never shows.
        r.guard = 1'b0;
      end
      default: begin
        r.value = sum[39:0];
      end
    endcase
    return r;
  endfunction : acc_step

  // Register read mux; unmapped addresses return zero.
  function automatic logic [31:0] reg_read(input acs_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    case (a)
      OFF_SR: d[15:0] = s.sr;
      OFF_CORE: begin
        d[CORE_IPL3] = s.ipl3;
        d[CORE_SAT31] = s.sat31;
        d[CORE_SATB] = s.sat_b;
        d[CORE_SATA] = s.sat_a;
      end
      OFF_INTC: begin
        d[INTC_TRAP_EN] = s.trap_en;
        d[INTC_NEST_DIS] = s.nest_dis;
      end
      OFF_ISTAT: d[IRQ_W-1:0] = s.irq_stat;
      OFF_IMASK: d[IRQ_W-1:0] = s.irq_mask;
      OFF_ACCA_LO: d = s.acc_a[31:0];
      OFF_ACCA_HI: d[7:0] = s.acc_a[39:32];
      OFF_ACCB_LO: d = s.acc_b[31:0];
      OFF_ACCB_HI: d[7:0] = s.acc_b[39:32];
      OFF_ALU_RES: d[15:0] = s.alu_result;
      default: d = '0;
    endcase
    return d;
  endfunction : reg_read

  //////////////////////////////////////////////////////////////////////////////
  // Flag generation for the word/byte ALU.
  acs_alu_flags u_alu_flags (
    .op(alu_op),
    .c_in(st.sr[SR_C]),
    .z_in(st.sr[SR_Z]),
    .res(alu_res)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    nx = st;
    rd_req = hsel && hready && htrans[1] && !hwrite && (haddr[31:8] == 24'h000000);
    wr_req = hsel && hready && htrans[1] && hwrite && (haddr[31:8] == 24'h000000);
    mode_sel = acc_op.sel_b ? acs_mode(st.sat_b, st.sat31) : acs_mode(st.sat_a, st.sat31);
    ares = acc_step(acc_op.sel_b ? st.acc_b : st.acc_a, acc_op, mode_sel);
    clip_new = 1'b0;
    events = '0;
    if (clk_en) begin
      nx.hreadyout = 1'b1;
      nx.hresp = 1'b0;

      // Writes land at the end of their data phase; hwdata is only valid there.
      if (st.wr_pend) begin
        case (st.wr_addr)
          OFF_SR: begin
            nx.sr[SR_C] = hwdata[SR_C];
            nx.sr[SR_Z] = hwdata[SR_Z];
            nx.sr[SR_OV] = hwdata[SR_OV];
            nx.sr[SR_N] = hwdata[SR_N];
            nx.sr[SR_DC] = hwdata[SR_DC];
            if (!st.nest_dis) begin
              nx.sr[SR_IPL_LO+:3] = hwdata[SR_IPL_LO+:3];
            end
            // Software can only clear the sticky clip flags.
            nx.sr[SR_SA] = st.sr[SR_SA] & hwdata[SR_SA];
            nx.sr[SR_SB] = st.sr[SR_SB] & hwdata[SR_SB];
          end
          OFF_CORE: begin
            nx.ipl3 = hwdata[CORE_IPL3];
            nx.sat31 = hwdata[CORE_SAT31];
            nx.sat_b = hwdata[CORE_SATB];
            nx.sat_a = hwdata[CORE_SATA];
          end
          OFF_INTC: begin
            nx.trap_en = hwdata[INTC_TRAP_EN];
            nx.nest_dis = hwdata[INTC_NEST_DIS];
          end
          OFF_ISTAT: nx.irq_stat = st.irq_stat & ~hwdata[IRQ_W-1:0];
          OFF_IMASK: nx.irq_mask = hwdata[IRQ_W-1:0];
          OFF_ACCA_LO: nx.acc_a[31:0] = hwdata;
          OFF_ACCA_HI: nx.acc_a[39:32] = hwdata[7:0];
          OFF_ACCB_LO: nx.acc_b[31:0] = hwdata;
          OFF_ACCB_HI: nx.acc_b[39:32] = hwdata[7:0];
          OFF_ALU_RES: nx.alu_result = hwdata[15:0];
          default: nx.wr_pend = 1'b0;
        endcase
      end
      nx.wr_pend = wr_req;
      nx.wr_addr = haddr[7:0];
      // Reads sample the state before a write in the same edge's data phase.
      if (rd_req) begin
        nx.hrdata = reg_read(st, haddr[7:0]);
      end

      // The ALU updates after the software write, so a hardware result wins.
      if (alu_op.valid) begin
        nx.alu_result = alu_res.result;
        nx.sr[SR_DC] = alu_res.dc;
        nx.sr[SR_N] = alu_res.n;
        nx.sr[SR_OV] = alu_res.ov;
        nx.sr[SR_Z] = alu_res.z;
        nx.sr[SR_C] = alu_res.c;
      end
      nx.sr[SR_RA] = repeat_busy;

      if (acc_op.valid) begin
        if (acc_op.sel_b) begin
          nx.acc_b = ares.value;
          nx.sr[SR_OB] = ares.guard;
          clip_new = ares.clip && !st.sr[SR_SB];
          nx.sr[SR_SB] = nx.sr[SR_SB] | ares.clip;
          events[IRQ_CLIP_B] = ares.clip;
        end else begin
          nx.acc_a = ares.value;
          nx.sr[SR_OA] = ares.guard;
          clip_new = ares.clip && !st.sr[SR_SA];
          nx.sr[SR_SA] = nx.sr[SR_SA] | ares.clip;
          events[IRQ_CLIP_A] = ares.clip;
        end
      end
      nx.trap = clip_new && st.trap_en && (mode_sel == ACS_MODE_WRAP);
      events[IRQ_TRAP] = nx.trap;

      nx.sr[SR_OAB] = nx.sr[SR_OA] | nx.sr[SR_OB];
      nx.sr[SR_SAB] = nx.sr[SR_SA] | nx.sr[SR_SB];
      nx.sr[9] = 1'b0;

      // A new event beats a software clear landing on the same edge.
      nx.irq_stat = nx.irq_stat | events;
      nx.irq = |(nx.irq_stat & nx.irq_mask);
      nx.ipl_eff = {nx.ipl3, nx.sr[SR_IPL_LO+:3]};
      nx.user_int_off = nx.ipl3 || (nx.sr[SR_IPL_LO+:3] == IPL_USER_OFF);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ACS_STATE_RESET;
    end else begin
      st <= nx;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign cpu_status_word = st.sr;
  assign acc_a = st.acc_a;
  assign acc_b = st.acc_b;
  assign alu_result = st.alu_result;
  assign ipl_effective = st.ipl_eff;
  assign user_int_disable = st.user_int_off;
  assign arith_warning_trap = st.trap;
  assign irq = st.irq;

endmodule : acs_status_core

//--- hdl/acs_pkg.sv
// Constants, carriers and state layout for the accumulator saturation and status block.
package acs_pkg;

  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int IRQ_W = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFF_SR = 8'h00;
  localparam logic [7:0] OFF_CORE = 8'h04;
  localparam logic [7:0] OFF_INTC = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_ACCA_LO = 8'h14;
  localparam logic [7:0] OFF_ACCA_HI = 8'h18;
  localparam logic [7:0] OFF_ACCB_LO = 8'h1c;
  localparam logic [7:0] OFF_ACCB_HI = 8'h20;
  localparam logic [7:0] OFF_ALU_RES = 8'h24;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_OV = 2;
  localparam int SR_N = 3;
  localparam int SR_RA = 4;
  localparam int SR_IPL_LO = 5;
  localparam int SR_DC = 8;
  localparam int SR_SAB = 10;
  localparam int SR_OAB = 11;
  localparam int SR_SB = 12;
  localparam int SR_SA = 13;
  localparam int SR_OB = 14;
  localparam int SR_OA = 15;
  localparam int CORE_IPL3 = 3;
  localparam int CORE_SAT31 = 4;
  localparam int CORE_SATB = 6;
  localparam int CORE_SATA = 7;
  localparam int INTC_TRAP_EN = 8;
  localparam int INTC_NEST_DIS = 15;
  localparam int IRQ_CLIP_A = 0;
  localparam int IRQ_CLIP_B = 1;
  localparam int IRQ_TRAP = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Values.
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [2:0] IPL_USER_OFF = 3'h7;
  localparam logic [39:0] SAT39_POS = 40'h7fffffffff;
  localparam logic [39:0] SAT39_NEG = 40'h8000000000;
  localparam logic [39:0] SAT31_POS = 40'h007fffffff;
  localparam logic [39:0] SAT31_NEG = 40'hff80000000;

  typedef enum logic [1:0] {ACS_MODE_WRAP, ACS_MODE_SAT39, ACS_MODE_SAT31} acs_sat_mode_t;

  typedef struct packed {
    logic valid;
    logic byte_mode;
    logic subtract;
    logic with_carry;
    logic affects_z;
    logic [15:0] opa;
    logic [15:0] opb;
  } acs_alu_op_t;

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
    logic [15:0] result;
  } acs_alu_res_t;

  typedef struct packed {
    logic valid;
    logic sel_b;
    logic subtract;
    logic [39:0] operand;
  } acs_acc_op_t;

  typedef struct packed {
    logic [39:0] value;
    logic clip;
    logic guard;
  } acs_acc_res_t;

  typedef struct packed {
    logic [15:0] sr;
    logic ipl3;
    logic sat31;
    logic sat_a;
    logic sat_b;
    logic nest_dis;
    logic trap_en;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic [15:0] alu_result;
    logic [3:0] ipl_eff;
    logic user_int_off;
    logic irq;
    logic trap;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic hreadyout;
    logic hresp;
  } acs_state_t;

  localparam acs_state_t ACS_STATE_RESET = '{hreadyout: 1'b1, sr: SR_RESET, default: '0};

endpackage : acs_pkg

//--- hdl/acs_alu_flags.sv
// Word and byte adder with the status flags it produces.
`timescale 1ns/10ps
module acs_alu_flags (
  input wire acs_pkg::acs_alu_op_t op,
  input wire logic c_in,
  input wire logic z_in,
  output acs_pkg::acs_alu_res_t res
);
  import acs_pkg::*;

  logic [15:0] b_eff;
  logic cin;
  logic [16:0] sum;
  logic [8:0] lo;
  logic [4:0] nib;
  logic zero;

  always_comb begin
    b_eff = op.subtract ? ~op.opb : op.opb;
    // Carry set means no borrow, so a plain subtract feeds a one in.
    cin = op.with_carry ? c_in : op.subtract;
    sum = {1'b0, op.opa} + {1'b0, b_eff} + {16'h0000, cin};
    lo = {1'b0, op.opa[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
    nib = {1'b0, op.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    res.result = sum[15:0];
    if (op.byte_mode) begin
      res.dc = nib[4];
      res.c = lo[8];
      res.n = sum[7];
      res.ov = (op.opa[7] == b_eff[7]) && (sum[7] != op.opa[7]);
      zero = (sum[7:0] == 8'h00);
    end else begin
      res.dc = lo[8];
      res.c = sum[16];
      res.n = sum[15];
      res.ov = (op.opa[15] == b_eff[15]) && (sum[15] != op.opa[15]);
      zero = (sum[15:0] == 16'h0000);
    end
    // Carry-chained operations may only clear zero, so multiword results test as one.
    if (!op.affects_z) begin
      res.z = z_in;
    end else if (op.with_carry) begin
      res.z = z_in & zero;
    end else begin
      res.z = zero;
    end
  end

endmodule : acs_alu_flags

//--- bench/acs_status_core_props.sv
// Port-level checks for the status and saturation block.
`timescale 1ns/10ps
module acs_status_core_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire acs_pkg::acs_alu_op_t alu_op,
  input wire acs_pkg::acs_acc_op_t acc_op,
  input wire logic repeat_busy,
  input wire logic [15:0] cpu_status_word,
  input wire logic [3:0] ipl_effective,
  input wire logic user_int_disable,
  input wire logic arith_warning_trap
);
  import acs_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_ipl_concat: assert property (ipl_effective[2:0] == cpu_status_word[7:5])
    else $error("effective level low bits differ from status word");
  a_user_int_off: assert property (user_int_disable == (ipl_effective[3] | (cpu_status_word[7:5] == 3'h7)))
    else $error("user interrupt disable wrong");
  a_sab_or: assert property (cpu_status_word[10] == (cpu_status_word[13] | cpu_status_word[12]))
    else $error("combined sticky flag wrong");
  a_oab_or: assert property (cpu_status_word[11] == (cpu_status_word[15] | cpu_status_word[14]))
    else $error("combined guard flag wrong");
  a_repeat_follow: assert property (clk_en |=> cpu_status_word[4] == $past(repeat_busy))
    else $error("repeat flag does not follow loop activity");
  // A sticky flag may only drop two edges after a write address phase.
  a_sticky_keep: assert property ($fell(cpu_status_word[13]) |-> $past(hsel && hwrite && htrans[1], 2))
    else $error("sticky flag dropped without a write");
  a_clip_cause: assert property ($rose(cpu_status_word[13]) |-> $past(acc_op.valid && !acc_op.sel_b))
    else $error("sticky flag set without an accumulator operation");
  a_trap_cause: assert property (arith_warning_trap |-> $rose(cpu_status_word[13]) || $rose(cpu_status_word[12]))
    else $error("trap without a new sticky flag");
  a_zero_hold: assert property ($changed(cpu_status_word[1]) |-> $past(alu_op.valid && alu_op.affects_z)
    || $past(hsel && hwrite && htrans[1], 2))
    else $error("zero flag changed without cause");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  c_trap: cover property (arith_warning_trap);
  c_sticky: cover property ($rose(cpu_status_word[13]));
  c_ipl_high: cover property (user_int_disable && ipl_effective[3]);
endmodule : acs_status_core_props

bind acs_status_core acs_status_core_props acs_status_core_props_i (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .alu_op(alu_op), .acc_op(acc_op), .repeat_busy(repeat_busy), .cpu_status_word(cpu_status_word),
  .ipl_effective(ipl_effective), .user_int_disable(user_int_disable), .arith_warning_trap(arith_warning_trap));

//--- bench/testbench.sv
// Directed bench for the status and saturation block.
`timescale 1ns/10ps
module testbench;
  import acs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic repeat_busy = 1'b0;
  acs_alu_op_t alu_op = '0;
  acs_acc_op_t acc_op = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic user_int_disable;
  logic arith_warning_trap;
  logic irq;
  logic [15:0] cpu_status_word;
  logic [15:0] alu_result;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic [3:0] ipl_effective;
  logic [31:0] q;
  logic trap_now;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 hclk = ~hclk;
  acs_status_core acs_status_core_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alu_op(alu_op), .acc_op(acc_op),
    .repeat_busy(repeat_busy), .cpu_status_word(cpu_status_word), .acc_a(acc_a), .acc_b(acc_b),
    .alu_result(alu_result), .ipl_effective(ipl_effective), .user_int_disable(user_int_disable),
    .arith_warning_trap(arith_warning_trap), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One extra edge after the data phase lets derived outputs settle before they are compared.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge hclk);
    #1;
  endtask : bus
  task automatic alu(input logic bm, sb, az, input logic [15:0] a, b, r, input logic [4:0] f);
    @(posedge hclk);
    alu_op <= {1'b1, bm, sb, 1'b0, az, a, b};
    @(posedge hclk);
    alu_op.valid <= 1'b0;
    #1;
    chk("alu_result", 40'(r), 40'(alu_result));
    // Half borrow polarity on subtraction is left unchecked.
    chk("alu_flags", 40'({~sb & f[4], f[3:0]}), 40'({~sb & cpu_status_word[8], cpu_status_word[3:0]}));
  endtask : alu
  task automatic acc(input logic s, sb, input logic [39:0] v);
    @(posedge hclk);
    acc_op <= {1'b1, s, sb, v};
    @(posedge hclk);
    acc_op.valid <= 1'b0;
    #1;
    trap_now = arith_warning_trap;
  endtask : acc
  task automatic load(input logic s, input logic [39:0] v);
    bus(1'b1, s ? OFF_ACCB_LO : OFF_ACCA_LO, v[31:0]);
    bus(1'b1, s ? OFF_ACCB_HI : OFF_ACCA_HI, {24'h0, v[39:32]});
  endtask : load
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFF_SR, 32'h0);
    chk("sr_reset", 40'(SR_RESET), 40'(q));
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 40'h0, 40'(q));
    alu(1'b0, 1'b0, 1'b1, 16'h00ff, 16'h0001, 16'h0100, 5'h10);
    alu(1'b1, 1'b0, 1'b1, 16'h000f, 16'h0001, 16'h0010, 5'h10);
    alu(1'b0, 1'b0, 1'b1, 16'h7fff, 16'h0001, 16'h8000, 5'h1c);
    alu(1'b0, 1'b0, 1'b1, 16'hffff, 16'h0001, 16'h0000, 5'h13);
    alu(1'b0, 1'b0, 1'b0, 16'h0001, 16'h0001, 16'h0002, 5'h02);
    alu(1'b0, 1'b1, 1'b1, 16'h0001, 16'h0002, 16'hffff, 5'h08);
    alu(1'b0, 1'b1, 1'b1, 16'h8000, 16'h0001, 16'h7fff, 5'h05);
    bus(1'b1, OFF_SR, 32'he0);
    chk("ipl", 40'h0f, 40'({ipl_effective, user_int_disable}));
    bus(1'b1, OFF_SR, 32'h20);
    chk("ipl", 40'h02, 40'({ipl_effective, user_int_disable}));
    bus(1'b1, OFF_CORE, 32'h08);
    chk("ipl", 40'h13, 40'({ipl_effective, user_int_disable}));
    bus(1'b1, OFF_CORE, 32'h0);
    bus(1'b1, OFF_INTC, 32'h8000);
    bus(1'b1, OFF_SR, 32'h60);
    chk("ipl", 40'h02, 40'({ipl_effective, user_int_disable}));
    bus(1'b1, OFF_INTC, 32'h100);
    bus(1'b1, OFF_IMASK, 32'h7);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      repeat_busy <= ~i[0];
      repeat (2) @(posedge hclk);
      #1;
      chk("repeat", 40'(!i[0]), 40'(cpu_status_word[4]));
    end
    // With the clock enable low the repeat flag must not follow its input.
    @(posedge hclk);
    clk_en <= 1'b0;
    repeat_busy <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    chk("freeze", 40'h0, 40'(cpu_status_word[4]));
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk("unfreeze", 40'h0, 40'(cpu_status_word[4]));
    load(1'b0, 40'h7fffffffff);
    acc(1'b0, 1'b0, 40'h1);
    chk("acc_a", 40'h8000000000, acc_a);
    chk("sr_acc", 40'h2b, 40'(cpu_status_word[15:10]));
    chk("trap_irq", 40'h3, 40'({trap_now, irq}));
    acc(1'b0, 1'b0, 40'h0);
    chk("sticky", 40'h2, 40'({cpu_status_word[13], trap_now}));
    bus(1'b0, OFF_ISTAT, 32'h0);
    chk("istat", 40'h5, 40'(q));
    bus(1'b1, OFF_ISTAT, 32'h5);
    chk("irq_clear", 40'h0, 40'(irq));
    bus(1'b1, OFF_SR, 32'h0);
    chk("sab_clear", 40'h0, 40'({cpu_status_word[13], cpu_status_word[10]}));
    bus(1'b1, OFF_IMASK, 32'h0);
    load(1'b1, 40'h8000000000);
    acc(1'b1, 1'b1, 40'h1);
    chk("acc_b", 40'h7fffffffff, acc_b);
    chk("masked", 40'h2, 40'({trap_now, irq}));
    bus(1'b0, OFF_ISTAT, 32'h0);
    chk("istat", 40'h6, 40'(q));
    bus(1'b1, OFF_ISTAT, 32'h7);
    bus(1'b1, OFF_IMASK, 32'h7);
    bus(1'b1, OFF_CORE, 32'hc0);
    bus(1'b1, OFF_SR, 32'h0);
    load(1'b0, 40'h7fffffffff);
    acc(1'b0, 1'b0, 40'h1);
    chk("sat39_a", 40'h7fffffffff, acc_a);
    chk("sat39_sr", 40'h6, 40'({cpu_status_word[13], cpu_status_word[10], trap_now}));
    load(1'b1, 40'h8000000000);
    acc(1'b1, 1'b1, 40'h1);
    chk("sat39_b", 40'h8000000000, acc_b);
    bus(1'b1, OFF_CORE, 32'hd0);
    bus(1'b1, OFF_SR, 32'h0);
    load(1'b0, 40'h007fffffff);
    acc(1'b0, 1'b0, 40'h1);
    chk("sat31_a", 40'h007fffffff, acc_a);
    load(1'b1, 40'hff80000000);
    acc(1'b1, 1'b1, 40'h1);
    chk("sat31_b", 40'hff80000000, acc_b);
    chk("sat31_sr", 40'h0d, 40'(cpu_status_word[15:10]));
    bus(1'b0, OFF_CORE, 32'h0);
    chk("core", 40'hd0, 40'(q));
    final_report();
  end
endmodule : testbench
